// ---- design/mmsx_exec.sv ----
`include "mmsx_consts.svh"

// Contract
// RQ1: System register load copies the whole source word; source unchanged.
// RQ2: Load source comes from the low register field, number from the other.
// RQ3: Number 5 loads the status word bit for bit from the source.
// RQ4: Interrupts are not sampled while the status word is being written.
// RQ5: A status load blocks interrupts from its first cycle on.
// RQ6: Register copy moves the word unchanged, flags untouched.
// RQ7: Short move sign-extends the 5-bit immediate to a word.
// RQ8: Long move takes low half from bits 31:16, high from 47:32.
// RQ9: Address add: register plus sign-extended 16-bit immediate.
// RQ10: Address and upper adds never touch any status flag.
// RQ11: Upper add adds immediate shifted up 16 with zero low half.
// RQ12: Word product: high word to third register, low to second.
// RQ13: Word immediate is 5 low bits plus 4 high bits.
// RQ14: Same high and low target ends up holding the high word.
// RQ15: Register word product with reg1 equal reg3 need not be right.
// RQ16: Halfword product multiplies low halves, word result to second.
// RQ17: Short halfword product sign-extends 5-bit immediate to a halfword.
// RQ18: Halfword immediate product uses source low half and 16-bit value.
// RQ19: Halfword products ignore the upper source halves.
// RQ20: Unsigned word product zero-extends operands and the immediate.
// RQ21: Signed word product treats operands as two's complement.
// RQ22: No move or product in this group changes any flag.
module mmsx_exec
  import mmsx_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        INSTR_VALID_IN,
  input  wire logic [47:0] INSTR_IN,
  input  wire logic        IRQ_PENDING_IN,
  output logic             READY_OUT,
  output logic             DONE_OUT,
  output logic             ILLEGAL_OUT,
  output logic             WB_VALID_OUT,
  output logic [4:0]       WB_ADDR_OUT,
  output logic [31:0]      WB_DATA_OUT,
  output logic             SYSREG_WE_OUT,
  output logic [4:0]       SYSREG_NUM_OUT,
  output logic [31:0]      SYSREG_DATA_OUT,
  output logic [31:0]      PSW_OUT,
  output logic             IRQ_SAMPLE_EN_OUT,
  output logic             IRQ_ACCEPT_OUT
);

  mmsx_rf_if rf ();

  mmsx_state_t state_ff;
  mmsx_state_t nxt_state;
  mmsx_op_t    op_ff;
  mmsx_op_t    dec_op;
  logic        sgn_ff;
  logic [4:0]  src_ff;
  logic [4:0]  dst_ff;
  logic [4:0]  hi_ff;
  logic [31:0] imm_ff;
  logic [31:0] dec_imm;
  logic [31:0] res_ff;
  logic [31:0] nxt_res;
  logic [31:0] mul_a;
  logic [31:0] mul_b;
  logic [63:0] prod;
  logic [31:0] psw_ff;
  logic        done_ff;
  logic        ill_ff;
  logic        wb_valid_ff;
  logic [4:0]  wb_addr_ff;
  logic [31:0] wb_data_ff;
  logic        sr_we_ff;
  logic [4:0]  sr_num_ff;
  logic [31:0] sr_data_ff;
  logic        psw_load_now;
  logic        psw_load_busy;

  // ------------------------------------------------------------
  // Field helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] sx5(input logic [4:0] v);
    sx5 = {{27{v[4]}}, v};
  endfunction

  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction

  // Decode of the first halfword and the extension halfword
  function automatic mmsx_op_t decode(input logic [47:0] ins);
    logic [5:0] opc;
    opc = ins[10:5];
    decode = OP_BAD;
    if (opc == `MMSX_OPC_COPY) begin
      decode = OP_COPY;
    end else if (opc == `MMSX_OPC_MOVI5) begin
      decode = OP_MOVI5;
    end else if (opc == `MMSX_OPC_ADDI && ins[15:11] == 5'h00) begin
      decode = OP_MOVI32;
    end else if (opc == `MMSX_OPC_ADDI) begin
      decode = OP_ADDI;
    end else if (opc == `MMSX_OPC_ADDHI) begin
      decode = OP_ADDHI;
    end else if (opc == `MMSX_OPC_HALFWORD_PRODUCT) begin
      decode = OP_HALFWORD_PRODUCT;
    end else if (opc == `MMSX_OPC_MULHI5) begin
      decode = OP_MULHI5;
    end else if (opc == `MMSX_OPC_MULHI16) begin
      decode = OP_MULHI16;
    end else if (opc == `MMSX_OPC_EXT) begin
      if (ins[26:16] == `MMSX_SUB_SYSTEM_REGISTER_LOAD && ins[31:27] == 5'h00) begin
        decode = OP_SYSTEM_REGISTER_LOAD;
      end else if (ins[26:16] == `MMSX_SUB_MULW ||
                   ins[26:16] == `MMSX_SUB_MULWU) begin
        decode = OP_MULW;
      end else if (ins[26:22] == `MMSX_SUB_MULWI && !ins[16]) begin
        decode = OP_MULWI;
      end
    end
  endfunction

  assign dec_op = decode(INSTR_IN);

  // ------------------------------------------------------------
  // Immediate assembly
  // ------------------------------------------------------------
  always_comb begin
    dec_imm = 32'h0000_0000;
    case (dec_op)
      OP_MOVI5, OP_MULHI5: begin
        dec_imm = sx5(INSTR_IN[4:0]); // RQ7 RQ17
      end
      OP_MOVI32: begin
        dec_imm = {INSTR_IN[47:32], INSTR_IN[31:16]}; // RQ8
      end
      OP_ADDI: begin
        dec_imm = sx16(INSTR_IN[31:16]); // RQ9
      end
      OP_ADDHI: begin
        dec_imm = {INSTR_IN[31:16], 16'h0000}; // RQ11
      end
      OP_MULHI16: begin
        dec_imm = sx16(INSTR_IN[31:16]); // RQ18
      end
      OP_MULWI: begin
        // 4 high bits join 5 low bits; unsigned form zero-extends
        if (INSTR_IN[17]) begin
          dec_imm = {23'h000000, INSTR_IN[21:18], INSTR_IN[4:0]}; // RQ20
        end else begin
          dec_imm = {{23{INSTR_IN[21]}}, INSTR_IN[21:18],
                     INSTR_IN[4:0]}; // RQ13 RQ21
        end
      end
      default: begin
        dec_imm = 32'h0000_0000;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Instruction latch
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      op_ff  <= OP_BAD;
      sgn_ff <= 1'b0;
      src_ff <= 5'h00;
      dst_ff <= 5'h00;
      hi_ff  <= 5'h00;
      imm_ff <= 32'h0000_0000;
    end else if (state_ff == ST_IDLE && INSTR_VALID_IN) begin
      op_ff  <= dec_op;
      src_ff <= INSTR_IN[4:0]; // RQ2
      dst_ff <= INSTR_IN[15:11]; // RQ2
      hi_ff  <= INSTR_IN[31:27];
      imm_ff <= dec_imm;
      if (dec_op == OP_MULW) begin
        sgn_ff <= !INSTR_IN[17]; // RQ20 RQ21
      end else if (dec_op == OP_MULWI) begin
        sgn_ff <= !INSTR_IN[17];
      end else begin
        sgn_ff <= 1'b1;
      end
      if (dec_op == OP_MOVI32) begin
        dst_ff <= INSTR_IN[4:0]; // RQ8
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (INSTR_VALID_IN && dec_op != OP_BAD) begin
          nxt_state = ST_READ;
        end
      end
      ST_READ: begin
        nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (op_ff == OP_HALFWORD_PRODUCT || op_ff == OP_MULHI5 ||
            op_ff == OP_MULHI16 || op_ff == OP_MULW ||
            op_ff == OP_MULWI) begin
          nxt_state = ST_MUL;
        end else begin
          nxt_state = ST_WB_LO;
        end
      end
      ST_MUL: begin
        nxt_state = ST_WB_LO;
      end
      ST_WB_LO: begin
        if (op_ff == OP_MULW || op_ff == OP_MULWI) begin
          nxt_state = ST_WB_HI;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WB_HI: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // Register file and multiplier
  // ------------------------------------------------------------
  mmsx_regmem u_regmem (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .rf     (rf.mem)
  );

  // Port A reads the first field, port B the second
  assign rf.rd_a_addr = src_ff;
  assign rf.rd_b_addr = dst_ff;

  always_comb begin
    mul_a = rf.rd_b_data;
    mul_b = rf.rd_a_data;
    case (op_ff)
      OP_HALFWORD_PRODUCT: begin
        mul_a = sx16(rf.rd_b_data[15:0]); // RQ16 RQ19
        mul_b = sx16(rf.rd_a_data[15:0]); // RQ16 RQ19
      end
      OP_MULHI5: begin
        mul_a = sx16(rf.rd_b_data[15:0]); // RQ17 RQ19
        mul_b = imm_ff;
      end
      OP_MULHI16: begin
        mul_a = sx16(rf.rd_a_data[15:0]); // RQ18 RQ19
        mul_b = imm_ff;
      end
      OP_MULWI: begin
        mul_a = rf.rd_b_data;
        mul_b = imm_ff; // RQ13
      end
      default: begin
        mul_a = rf.rd_b_data; // RQ12
        mul_b = rf.rd_a_data;
      end
    endcase
  end

  // Operands are both read before any write, so RQ15 holds anyway
  mmsx_mul u_mul (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .signed_in (sgn_ff), // RQ20 RQ21
    .a_in      (mul_a), // RQ15
    .b_in      (mul_b),
    .prod_out  (prod)
  );

  // ------------------------------------------------------------
  // Move results
  // ------------------------------------------------------------
  always_comb begin
    nxt_res = res_ff;
    case (op_ff)
      OP_COPY: begin
        nxt_res = rf.rd_a_data; // RQ6
      end
      OP_MOVI5, OP_MOVI32: begin
        nxt_res = imm_ff; // RQ7 RQ8
      end
      OP_ADDI, OP_ADDHI: begin
        nxt_res = rf.rd_a_data + imm_ff; // RQ9 RQ11
      end
      OP_SYSTEM_REGISTER_LOAD: begin
        nxt_res = rf.rd_a_data; // RQ1
      end
      default: begin
        nxt_res = res_ff;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      res_ff <= 32'h0000_0000;
    end else if (state_ff == ST_EXEC) begin
      res_ff <= nxt_res;
    end else if (state_ff == ST_MUL) begin
      res_ff <= prod[31:0];
    end
  end

  // ------------------------------------------------------------
  // Write-back; low word first so a shared target keeps high
  // ------------------------------------------------------------
  always_comb begin
    rf.wr_en   = 1'b0;
    rf.wr_addr = dst_ff;
    rf.wr_data = res_ff;
    if (state_ff == ST_WB_LO && op_ff != OP_SYSTEM_REGISTER_LOAD) begin
      rf.wr_en = 1'b1; // RQ12
    end else if (state_ff == ST_WB_HI) begin
      rf.wr_en   = 1'b1;
      rf.wr_addr = hi_ff; // RQ12 RQ14
      rf.wr_data = prod[63:32];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wb_valid_ff <= 1'b0;
      wb_addr_ff  <= 5'h00;
      wb_data_ff  <= 32'h0000_0000;
    end else begin
      wb_valid_ff <= rf.wr_en;
      if (rf.wr_en) begin
        wb_addr_ff <= rf.wr_addr;
        wb_data_ff <= rf.wr_data;
      end
    end
  end

  // ------------------------------------------------------------
  // System register load and status word
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sr_we_ff   <= 1'b0;
      sr_num_ff  <= 5'h00;
      sr_data_ff <= 32'h0000_0000;
    end else begin
      sr_we_ff <= (state_ff == ST_WB_LO && op_ff == OP_SYSTEM_REGISTER_LOAD);
      if (state_ff == ST_WB_LO && op_ff == OP_SYSTEM_REGISTER_LOAD) begin
        sr_num_ff  <= dst_ff; // RQ1
        sr_data_ff <= res_ff; // RQ1
      end
    end
  end

  // Flags change only through a status load
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      psw_ff <= `MMSX_PSW_RESET;
    end else if (state_ff == ST_WB_LO && op_ff == OP_SYSTEM_REGISTER_LOAD &&
                 dst_ff == `MMSX_SR_PSW) begin
      psw_ff <= res_ff; // RQ3 RQ10 RQ22
    end
  end

  // ------------------------------------------------------------
  // Interrupt sampling gate
  // ------------------------------------------------------------
  assign psw_load_now = (state_ff == ST_IDLE) && INSTR_VALID_IN &&
                        (dec_op == OP_SYSTEM_REGISTER_LOAD) &&
                        (INSTR_IN[15:11] == `MMSX_SR_PSW);
  assign psw_load_busy = (state_ff != ST_IDLE) && (op_ff == OP_SYSTEM_REGISTER_LOAD) &&
                         (dst_ff == `MMSX_SR_PSW);

  assign IRQ_SAMPLE_EN_OUT = !psw_ff[`MMSX_PSW_ID_BIT] &&
                             !psw_load_now && !psw_load_busy; // RQ4 RQ5
  assign IRQ_ACCEPT_OUT = IRQ_PENDING_IN && IRQ_SAMPLE_EN_OUT;

  // ------------------------------------------------------------
  // Completion and status outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      done_ff <= 1'b0;
      ill_ff  <= 1'b0;
    end else begin
      done_ff <= (nxt_state == ST_IDLE) && (state_ff != ST_IDLE);
      ill_ff  <= (state_ff == ST_IDLE) && INSTR_VALID_IN &&
                 (dec_op == OP_BAD);
    end
  end

  assign READY_OUT       = (state_ff == ST_IDLE);
  assign DONE_OUT        = done_ff;
  assign ILLEGAL_OUT     = ill_ff;
  assign WB_VALID_OUT    = wb_valid_ff;
  assign WB_ADDR_OUT     = wb_addr_ff;
  assign WB_DATA_OUT     = wb_data_ff;
  assign SYSREG_WE_OUT   = sr_we_ff;
  assign SYSREG_NUM_OUT  = sr_num_ff;
  assign SYSREG_DATA_OUT = sr_data_ff;
  assign PSW_OUT         = psw_ff;

endmodule // mmsx_exec

// ---- design/mmsx_consts.svh ----
`ifndef MMSX_CONSTS_SVH
`define MMSX_CONSTS_SVH

// ------------------------------------------------------------
// Opcode fields of the first halfword
// ------------------------------------------------------------
`define MMSX_OPC_COPY      6'h00
`define MMSX_OPC_MOVI5     6'h10
`define MMSX_OPC_ADDI      6'h31
`define MMSX_OPC_ADDHI     6'h32
`define MMSX_OPC_MULHI16   6'h37
`define MMSX_OPC_HALFWORD_PRODUCT      6'h07
`define MMSX_OPC_MULHI5    6'h17
`define MMSX_OPC_EXT       6'h3f

// ------------------------------------------------------------
// Sub-opcodes of the second halfword
// ------------------------------------------------------------
`define MMSX_SUB_SYSTEM_REGISTER_LOAD      11'h020
`define MMSX_SUB_MULW      11'h220
`define MMSX_SUB_MULWU     11'h222
`define MMSX_SUB_MULWI     5'h09

// ------------------------------------------------------------
// Status word
// ------------------------------------------------------------
`define MMSX_SR_PSW        5'h05
`define MMSX_PSW_ID_BIT    5
`define MMSX_PSW_RESET     32'h0000_0020

`endif

// ---- design/mmsx_pkg.sv ----
package mmsx_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_EXEC, ST_MUL, ST_WB_LO, ST_WB_HI
  } mmsx_state_t;

  typedef enum logic [3:0] {
    OP_BAD, OP_COPY, OP_MOVI5, OP_MOVI32, OP_ADDI, OP_ADDHI,
    OP_HALFWORD_PRODUCT, OP_MULHI5, OP_MULHI16, OP_MULW, OP_MULWI, OP_SYSTEM_REGISTER_LOAD
  } mmsx_op_t;

endpackage

// ---- design/mmsx_rf_if.sv ----
interface mmsx_rf_if;
  logic [4:0]  rd_a_addr;
  logic [4:0]  rd_b_addr;
  logic [31:0] rd_a_data;
  logic [31:0] rd_b_data;
  logic        wr_en;
  logic [4:0]  wr_addr;
  logic [31:0] wr_data;

  modport ctrl (output rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data,
                input  rd_a_data, rd_b_data);
  modport mem  (input  rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data,
                output rd_a_data, rd_b_data);
endinterface

// ---- design/mmsx_regmem.sv ----
module mmsx_regmem (
  input wire logic clk_in,
  input wire logic rst_in,
  mmsx_rf_if.mem   rf
);

  logic [31:0] mem [32];
  logic [31:0] rd_a_ff;
  logic [31:0] rd_b_ff;

  // ------------------------------------------------------------
  // Storage; register zero is never written
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rf.wr_en && (rf.wr_addr != 5'h00)) begin
      mem[rf.wr_addr] <= rf.wr_data;
    end
  end

  // ------------------------------------------------------------
  // Registered read ports, zero register reads zero
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_a_ff <= 32'h0000_0000;
      rd_b_ff <= 32'h0000_0000;
    end else begin
      rd_a_ff <= (rf.rd_a_addr == 5'h00) ? 32'h0000_0000
                                         : mem[rf.rd_a_addr];
      rd_b_ff <= (rf.rd_b_addr == 5'h00) ? 32'h0000_0000
                                         : mem[rf.rd_b_addr];
    end
  end

  assign rf.rd_a_data = rd_a_ff;
  assign rf.rd_b_data = rd_b_ff;

endmodule // mmsx_regmem

// ---- design/mmsx_mul.sv ----
module mmsx_mul (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        signed_in,
  input  wire logic [31:0] a_in,
  input  wire logic [31:0] b_in,
  output logic      [63:0] prod_out
);

  logic signed [32:0] a_ext;
  logic signed [32:0] b_ext;
  logic signed [65:0] full;
  logic        [63:0] prod_ff;

  // ------------------------------------------------------------
  // One extra bit makes one signed multiplier serve both kinds
  // ------------------------------------------------------------
  assign a_ext = {signed_in & a_in[31], a_in};
  assign b_ext = {signed_in & b_in[31], b_in};
  assign full  = 66'(a_ext) * 66'(b_ext);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prod_ff <= 64'h0000_0000_0000_0000;
    end else begin
      prod_ff <= full[63:0];
    end
  end

  assign prod_out = prod_ff;

endmodule // mmsx_mul

// ---- tb/mmsx_exec_chk.sv ----
module mmsx_exec_chk (
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        INSTR_VALID_IN,
  input wire logic [47:0] INSTR_IN,
  input wire logic        IRQ_PENDING_IN,
  input wire logic        READY_OUT,
  input wire logic        DONE_OUT,
  input wire logic        ILLEGAL_OUT,
  input wire logic        SYSREG_WE_OUT,
  input wire logic [4:0]  SYSREG_NUM_OUT,
  input wire logic [31:0] SYSREG_DATA_OUT,
  input wire logic [31:0] PSW_OUT,
  input wire logic        IRQ_SAMPLE_EN_OUT,
  input wire logic        IRQ_ACCEPT_OUT
);
  timeunit 1ns;
  timeprecision 100ps;

  logic take;
  logic psw_ld;
  logic ldsr5_in;

  assign take     = READY_OUT && INSTR_VALID_IN;
  assign psw_ld   = SYSREG_WE_OUT && SYSREG_NUM_OUT == 5'h05;
  assign ldsr5_in = INSTR_IN[15:5] == {5'h05, 6'h3f} &&
                    INSTR_IN[31:16] == 16'h0020;

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  property p_done_pulse;
    DONE_OUT |=> !DONE_OUT;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");

  property p_latency;
    take |=> ILLEGAL_OUT or (!DONE_OUT [*3] ##[1:3] DONE_OUT);
  endproperty
  a_latency: assert property (p_latency) else $error("done latency");

  property p_done_ready;
    DONE_OUT |-> READY_OUT;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("not ready");

  property p_psw_load;
    psw_ld |-> PSW_OUT == SYSREG_DATA_OUT;
  endproperty
  a_psw_load: assert property (p_psw_load) else $error("psw load");

  property p_psw_hold;
    !psw_ld |-> PSW_OUT == $past(PSW_OUT);
  endproperty
  a_psw_hold: assert property (p_psw_hold) else $error("psw moved");

  property p_irq_block;
    take && ldsr5_in |-> !IRQ_SAMPLE_EN_OUT [*4];
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("irq open");

  property p_irq_write;
    psw_ld |-> $past(IRQ_SAMPLE_EN_OUT) == 1'b0;
  endproperty
  a_irq_write: assert property (p_irq_write) else $error("irq sampled");

  property p_irq_idle;
    READY_OUT && !INSTR_VALID_IN |-> IRQ_SAMPLE_EN_OUT == !PSW_OUT[5];
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq vs flag");

  property p_accept;
    IRQ_ACCEPT_OUT == (IRQ_PENDING_IN && IRQ_SAMPLE_EN_OUT);
  endproperty
  a_accept: assert property (p_accept) else $error("irq accept");
endmodule // mmsx_exec_chk

bind mmsx_exec mmsx_exec_chk u_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
  .INSTR_IN(INSTR_IN), .IRQ_PENDING_IN(IRQ_PENDING_IN),
  .READY_OUT(READY_OUT), .DONE_OUT(DONE_OUT), .ILLEGAL_OUT(ILLEGAL_OUT),
  .SYSREG_WE_OUT(SYSREG_WE_OUT), .SYSREG_NUM_OUT(SYSREG_NUM_OUT),
  .SYSREG_DATA_OUT(SYSREG_DATA_OUT), .PSW_OUT(PSW_OUT),
  .IRQ_SAMPLE_EN_OUT(IRQ_SAMPLE_EN_OUT), .IRQ_ACCEPT_OUT(IRQ_ACCEPT_OUT));

// ---- tb/test_move_multiply_sysreg_exec.sv ----
module test_move_multiply_sysreg_exec;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vld = 1'b0;
  logic [47:0] ins = 48'h0;
  logic        irq = 1'b0;
  logic        ready, done, ill, wb_v, sr_we, irq_en, irq_acc;
  logic [4:0]  wb_a, sr_num, a0, a1;
  logic [31:0] wb_d, sr_d, program_status_word, d0, d1;
  logic [31:0] psw_x = 32'h0000_0020;
  int          miscompares = 0;
  int          checks = 0;

  always #2.5 clk = ~clk;

  mmsx_exec DUT (
    .CLK_IN(clk), .RST_IN(rst), .INSTR_VALID_IN(vld), .INSTR_IN(ins),
    .IRQ_PENDING_IN(irq), .READY_OUT(ready), .DONE_OUT(done),
    .ILLEGAL_OUT(ill), .WB_VALID_OUT(wb_v), .WB_ADDR_OUT(wb_a),
    .WB_DATA_OUT(wb_d), .SYSREG_WE_OUT(sr_we), .SYSREG_NUM_OUT(sr_num),
    .SYSREG_DATA_OUT(sr_d), .PSW_OUT(program_status_word), .IRQ_SAMPLE_EN_OUT(irq_en),
    .IRQ_ACCEPT_OUT(irq_acc));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [47:0] enc(input logic [5:0] op,
    input logic [4:0] r1, input logic [4:0] r2, input logic [31:0] ext);
    return {ext, r2, op, r1};
  endfunction

  function automatic logic [63:0] mulw(input logic [31:0] a,
    input logic [31:0] b, input logic s);
    if (s) return $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
    return {32'h0, a} * {32'h0, b};
  endfunction

  // Offers one instruction, keeps the last two writes, checks latency
  task automatic exec(input logic [47:0] i, input int lat);
    int n = 1;
    @(posedge clk); #1;
    vld = 1'b1;
    ins = i;
    @(posedge clk); #1;
    vld = 1'b0;
    repeat (12) begin
      if (wb_v === 1'b1) begin
        a0 = a1;
        d0 = d1;
        a1 = wb_a;
        d1 = wb_d;
      end
      if (done === 1'b1 || ill === 1'b1) break;
      @(posedge clk); #1;
      n++;
    end
    chk(n, lat);
    chk(program_status_word, psw_x);
    if (n > 12) end_sim();
  endtask

  task automatic ld(input logic [4:0] r, input logic [31:0] v);
    exec(enc(6'h31, r, 5'd0, v), 4);
    chk({27'h0, a1}, {27'h0, r});
    chk(d1, v);
  endtask

  task automatic rd(input logic [4:0] r, input logic [31:0] v);
    exec(enc(6'h00, r, 5'd31, 32'h0), 4);
    chk(d1, v);
  endtask

  task automatic wchk(input logic [4:0] lo, input logic [4:0] hi,
    input logic [63:0] p);
    chk({27'h0, a0}, {27'h0, lo});
    chk(d0, p[31:0]);
    chk({27'h0, a1}, {27'h0, hi});
    chk(d1, p[63:32]);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    repeat (8) @(posedge clk);
    #1;
    chk(program_status_word, 32'h0000_0020);
    chk({31'h0, ready}, 32'h1);
    chk({31'h0, irq_en}, 32'h0);
    rst = 1'b0;
  endtask

  task automatic t_moves();
    ld(5'd1, 32'h8765_4321);
    exec(enc(6'h10, 5'h1d, 5'd2, 32'h0), 4);
    chk(d1, 32'hffff_fffd);
    exec(enc(6'h00, 5'd1, 5'd3, 32'h0), 4);
    chk(d1, 32'h8765_4321);
    rd(5'd1, 32'h8765_4321);
    exec(enc(6'h31, 5'd1, 5'd5, 32'h8000), 4);
    chk(d1, 32'h8764_c321);
    exec(enc(6'h32, 5'd1, 5'd6, 32'habcd), 4);
    chk(d1, 32'h3332_4321);
  endtask

  task automatic t_half();
    ld(5'd7, 32'h1234_fffe);
    ld(5'd8, 32'habcd_0003);
    exec(enc(6'h07, 5'd7, 5'd8, 32'h0), 5);
    chk(d1, 32'hffff_fffa);
    exec(enc(6'h17, 5'h1f, 5'd8, 32'h0), 5);
    chk(d1, 32'h0000_0006);
    exec(enc(6'h37, 5'd7, 5'd9, 32'h0005), 5);
    chk(d1, 32'hffff_fff6);
    chk({27'h0, a1}, 32'h9);
  endtask

  task automatic t_word();
    logic [63:0] p;
    ld(5'd10, 32'hffff_ffff);
    exec(enc(6'h3f, 5'd1, 5'd10, {5'd11, 11'h220}), 6);
    wchk(5'd10, 5'd11, mulw(32'hffff_ffff, 32'h8765_4321, 1'b1));
    ld(5'd10, 32'hffff_ffff);
    exec(enc(6'h3f, 5'd1, 5'd10, {5'd12, 11'h222}), 6);
    wchk(5'd10, 5'd12, mulw(32'hffff_ffff, 32'h8765_4321, 1'b0));
    ld(5'd13, 32'h3);
    exec(enc(6'h3f, 5'h10, 5'd13, {5'd14, 5'h09, 4'hf, 2'h0}), 6);
    wchk(5'd13, 5'd14, mulw(32'h3, 32'hffff_fff0, 1'b1));
    ld(5'd13, 32'h3);
    exec(enc(6'h3f, 5'h10, 5'd13, {5'd15, 5'h09, 4'hf, 2'h2}), 6);
    wchk(5'd13, 5'd15, mulw(32'h3, 32'h1f0, 1'b0));
    ld(5'd16, 32'h8765_4321);
    exec(enc(6'h3f, 5'd1, 5'd16, {5'd16, 11'h220}), 6);
    p = mulw(32'h8765_4321, 32'h8765_4321, 1'b1);
    wchk(5'd16, 5'd16, p);
    rd(5'd16, p[63:32]);
  endtask

  task automatic t_system_register_load();
    irq = 1'b1;
    ld(5'd17, 32'h0000_001f);
    psw_x = 32'h0000_001f;
    exec(enc(6'h3f, 5'd17, 5'd5, 32'h0020), 4);
    chk({27'h0, sr_num}, 32'h5);
    chk({31'h0, sr_we}, 32'h1);
    chk(sr_d, 32'h0000_001f);
    chk(program_status_word, 32'h0000_001f);
    chk({31'h0, irq_acc}, 32'h1);
    rd(5'd17, 32'h0000_001f);
    ld(5'd18, 32'h0000_0020);
    psw_x = 32'h0000_0020;
    exec(enc(6'h3f, 5'd18, 5'd5, 32'h0020), 4);
    chk({31'h0, irq_acc}, 32'h0);
    exec(enc(6'h3f, 5'd17, 5'd6, 32'h0020), 4);
    chk({27'h0, sr_num}, 32'h6);
    chk({31'h0, sr_we}, 32'h1);
    chk(sr_d, 32'h0000_001f);
    irq = 1'b0;
  endtask

  task automatic t_illegal();
    exec(enc(6'h3f, 5'd1, 5'd2, 32'h07ff), 1);
    chk({31'h0, ill}, 32'h1);
    rd(5'd1, 32'h8765_4321);
  endtask

  initial begin
    t_reset();
    t_moves();
    t_half();
    t_word();
    t_system_register_load();
    t_illegal();
    end_sim();
  end
endmodule // test_move_multiply_sysreg_exec
